// File: hw/wrkel_evbuf.sv
// two-entry valid/ready buffer for debounced key events
`timescale 1ns/100ps
module wrkel_evbuf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = wrkel_pkg::EVBUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt = (wp_r == PTR_LAST) ? '0 : wp_r + 1'b1;
    end
    if (pop)
      rp_nxt = (rp_r == PTR_LAST) ? '0 : rp_r + 1'b1;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule : wrkel_evbuf

// File: hw/wrkel_i2c_slave.sv
// oversampled two-wire slave: one control write, four-byte read
`timescale 1ns/100ps
module wrkel_i2c_slave (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [6:0] dev_addr_i,
  input wire logic [7:0] id_byte_i,
  input wire logic [7:0] ctrl_byte_i,
  input wire logic [7:0] key_byte_i,
  input wire logic [7:0] dur_byte_i,
  output logic sda_oe_o,
  output logic wr_stb_o,
  output logic [7:0] wr_data_o,
  output logic rd_done_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_ACKA, S_WRDATA, S_ACKW, S_TX, S_RACK
  } wrkel_i2c_state_t;

  wrkel_i2c_state_t state_r, state_nxt;
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt, wdata_nxt, nbyte;
  logic [1:0] idx_r, idx_nxt;
  logic rw_r, rw_nxt, ack_r, ack_nxt, oe_nxt, wstb_nxt, done_nxt;
  logic rise, fall, start, stop;

  assign rise = scl_s2_r && !scl_d_r;
  assign fall = !scl_s2_r && scl_d_r;
  // start/stop: sda moves while scl stays high
  assign start = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
  assign stop = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;

  function automatic logic [7:0] sel_byte(input logic [1:0] i,
      input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
      input logic [7:0] b3);
    case (i)
      wrkel_pkg::BYTE_ID: sel_byte = b0;
      wrkel_pkg::BYTE_CTRL: sel_byte = b1;
      wrkel_pkg::BYTE_KEY: sel_byte = b2;
      default: sel_byte = b3;
    endcase
  endfunction : sel_byte

  always_comb
  begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    idx_nxt = idx_r;
    rw_nxt = rw_r;
    ack_nxt = ack_r;
    oe_nxt = sda_oe_o;
    wstb_nxt = 1'b0;
    wdata_nxt = wr_data_o;
    done_nxt = 1'b0;
    nbyte = sel_byte(idx_r + 2'h1, id_byte_i, ctrl_byte_i, key_byte_i,
      dur_byte_i);
    if (start)
    begin
      state_nxt = S_ADDR;
      bit_nxt = '0;
      oe_nxt = 1'b0;
    end
    else if (stop)
    begin
      state_nxt = S_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        S_ADDR, S_WRDATA:
          if (rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            bit_nxt = bit_r + 4'h1;
          end
          else if (fall && bit_r == 4'h8)
          begin
            if (state_r == S_WRDATA)
            begin
              wstb_nxt = 1'b1;
              wdata_nxt = shift_r;
              state_nxt = S_ACKW;
              oe_nxt = 1'b1;
            end
            else if (shift_r[7:1] == dev_addr_i)
            begin
              rw_nxt = shift_r[0];
              state_nxt = S_ACKA;
              oe_nxt = 1'b1;
            end
            else
              state_nxt = S_IDLE;
          end
        S_ACKA:
          if (fall)
          begin
            bit_nxt = '0;
            if (rw_r)
            begin
              idx_nxt = wrkel_pkg::BYTE_ID;
              shift_nxt = id_byte_i;
              oe_nxt = !id_byte_i[7];
              state_nxt = S_TX;
            end
            else
            begin
              oe_nxt = 1'b0;
              state_nxt = S_WRDATA;
            end
          end
        S_ACKW:
          // further data bytes are left unacknowledged
          if (fall)
          begin
            oe_nxt = 1'b0;
            state_nxt = S_IDLE;
          end
        S_TX:
          if (rise)
            bit_nxt = bit_r + 4'h1;
          else if (fall)
          begin
            if (bit_r == 4'h8)
            begin
              oe_nxt = 1'b0;
              state_nxt = S_RACK;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = !shift_r[6];
            end
          end
        S_RACK:
          if (rise)
            ack_nxt = !sda_s2_r;
          else if (fall)
          begin
            if (!ack_r)
              state_nxt = S_IDLE;
            else if (idx_r == wrkel_pkg::BYTE_DUR)
            begin
              done_nxt = 1'b1;
              state_nxt = S_IDLE;
            end
            else
            begin
              idx_nxt = idx_r + 2'h1;
              shift_nxt = nbyte;
              oe_nxt = !nbyte[7];
              bit_nxt = '0;
              state_nxt = S_TX;
            end
          end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= S_IDLE;
      bit_r <= '0;
      shift_r <= '0;
      idx_r <= '0;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb_o <= 1'b0;
      wr_data_o <= '0;
      rd_done_o <= 1'b0;
    end
    else
    begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      idx_r <= idx_nxt;
      rw_r <= rw_nxt;
      ack_r <= ack_nxt;
      sda_oe_o <= oe_nxt;
      wr_stb_o <= wstb_nxt;
      wr_data_o <= wdata_nxt;
      rd_done_o <= done_nxt;
    end
  end
endmodule : wrkel_i2c_slave

// File: hw/wrkel_logger.sv
// key event logger top: debounce, event FIFO, duration timer, control
`timescale 1ns/100ps

module wrkel_logger #(
  parameter int unsigned TICK_CYCLES = wrkel_pkg::TICK_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = wrkel_pkg::DEBOUNCE_CYCLES,
  parameter logic [7:0] ID_VALUE = wrkel_pkg::ID_VALUE
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] key_code_i,
  input wire logic shutdown_pin_n_i,
  input wire logic addr_select_1_i,
  input wire logic addr_select_0_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  output logic force_drive_oe_o
);
  localparam int DEPTH = wrkel_pkg::FIFO_DEPTH;
  localparam logic [2:0] PTR_ONE = 3'h1;
  localparam logic [3:0] CNT_FULL = 4'(DEPTH);

  // pin synchronisers: stage 1 feeds stage 2 only
  logic [7:0] key_s1_r, key_s2_r;
  logic shutdown_pin_n_s1_r, shutdown_pin_n_s2_r, a1_s1_r, a1_s2_r, a0_s1_r, a0_s2_r;

  logic [7:0] cand_r, cand_nxt, stable_r, stable_nxt;
  logic [31:0] db_cnt_r, db_cnt_nxt;
  logic ev_valid_r, ev_valid_nxt;

  logic buf_in_ready, buf_out_valid, buf_out_ready;
  logic [7:0] buf_out_data;

  logic [7:0] key_r [DEPTH];
  logic [7:0] key_nxt [DEPTH];
  logic [7:0] dur_r [DEPTH];
  logic [7:0] dur_nxt [DEPTH];
  logic [2:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [2:0] cur_ptr_r, cur_ptr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic active_r, active_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic int_n_nxt, fde_r, fde_nxt, pdr_r, pdr_nxt, force_nxt;
  logic push, pop, tick_hit, clear, empty;
  logic wr_stb, rd_done, i2c_oe;
  logic [7:0] wr_data, ctrl_byte;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      key_s1_r <= wrkel_pkg::KEY_RESET;
      key_s2_r <= wrkel_pkg::KEY_RESET;
      shutdown_pin_n_s1_r <= 1'b1;
      shutdown_pin_n_s2_r <= 1'b1;
      a1_s1_r <= 1'b0;
      a1_s2_r <= 1'b0;
      a0_s1_r <= 1'b0;
      a0_s2_r <= 1'b0;
    end
    else
    begin
      key_s1_r <= key_code_i;
      key_s2_r <= key_s1_r;
      shutdown_pin_n_s1_r <= shutdown_pin_n_i;
      shutdown_pin_n_s2_r <= shutdown_pin_n_s1_r;
      a1_s1_r <= addr_select_1_i;
      a1_s2_r <= a1_s1_r;
      a0_s1_r <= addr_select_0_i;
      a0_s2_r <= a0_s1_r;
    end
  end

  // debounce: a code becomes an event once steady long enough
  always_comb
  begin
    cand_nxt = cand_r;
    stable_nxt = stable_r;
    db_cnt_nxt = db_cnt_r;
    ev_valid_nxt = ev_valid_r;
    if (ev_valid_r && buf_in_ready)
      ev_valid_nxt = 1'b0;
    if (key_s2_r != cand_r)
    begin
      cand_nxt = key_s2_r;
      db_cnt_nxt = '0;
    end
    else if (db_cnt_r < DEBOUNCE_CYCLES - 1)
      db_cnt_nxt = db_cnt_r + 32'h1;
    else if (cand_r != stable_r && !ev_valid_r)
    begin
      stable_nxt = cand_r;
      ev_valid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cand_r <= wrkel_pkg::KEY_RESET;
      stable_r <= wrkel_pkg::KEY_RESET;
      db_cnt_r <= '0;
      ev_valid_r <= 1'b0;
    end
    else
    begin
      cand_r <= cand_nxt;
      stable_r <= stable_nxt;
      db_cnt_r <= db_cnt_nxt;
      ev_valid_r <= ev_valid_nxt;
    end
  end

  // absorbs an event while the FIFO is busy popping
  wrkel_evbuf #(
    .WIDTH(8),
    .DEPTH(wrkel_pkg::EVBUF_DEPTH)
  ) u_evbuf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(ev_valid_r),
    .in_ready_o(buf_in_ready),
    .in_data_i(stable_r),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  assign empty = (cnt_r == 4'h0);
  assign ctrl_byte = {fde_r, pdr_r, empty,
    wrkel_pkg::CTRL_UNUSED_READ};

  wrkel_i2c_slave u_i2c (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .dev_addr_i({wrkel_pkg::ADDR_UPPER, a1_s2_r, a0_s2_r}),
    .id_byte_i(ID_VALUE),
    .ctrl_byte_i(ctrl_byte),
    .key_byte_i(key_r[rd_ptr_r]),
    .dur_byte_i(dur_r[rd_ptr_r]),
    .sda_oe_o(i2c_oe),
    .wr_stb_o(wr_stb),
    .wr_data_o(wr_data),
    .rd_done_o(rd_done)
  );

  // power-down write, held power-down or shutdown pin wipe the FIFO
  assign clear = !shutdown_pin_n_s2_r || pdr_r ||
    (wr_stb && wr_data[wrkel_pkg::CTRL_PDR_BIT]);
  // pop stalls the event path for a cycle to keep one writer per entry
  assign buf_out_ready = !rd_done || clear;
  assign push = buf_out_valid && buf_out_ready && !clear;
  assign pop = rd_done && !empty &&
    !(active_r && cur_ptr_r == rd_ptr_r) && !clear;
  assign tick_hit = active_r && (tick_r == TICK_CYCLES - 1);

  // per-entry next values
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_entry
    always_comb
    begin
      key_nxt[g] = key_r[g];
      dur_nxt[g] = dur_r[g];
      if (clear || (pop && rd_ptr_r == 3'(g)))
      begin
        key_nxt[g] = wrkel_pkg::KEY_RESET;
        dur_nxt[g] = wrkel_pkg::DUR_RESET;
      end
      else if (push && wr_ptr_r == 3'(g))
      begin
        key_nxt[g] = buf_out_data;
        dur_nxt[g] = wrkel_pkg::DUR_RESET;
      end
      else if (tick_hit && cur_ptr_r == 3'(g))
      begin
        dur_nxt[g][6:0] = dur_r[g][6:0] + 7'h1;
        dur_nxt[g][wrkel_pkg::DUR_OVF_BIT] = dur_r[g][wrkel_pkg::DUR_OVF_BIT]
          || (dur_r[g][6:0] == wrkel_pkg::DUR_COUNT_MAX);
      end
    end
  end

  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cur_ptr_nxt = cur_ptr_r;
    cnt_nxt = cnt_r;
    active_nxt = active_r;
    tick_nxt = tick_r;
    int_n_nxt = int_n_o;
    fde_nxt = fde_r;
    pdr_nxt = pdr_r;
    if (wr_stb)
    begin
      fde_nxt = wr_data[wrkel_pkg::CTRL_FDE_BIT];
      pdr_nxt = wr_data[wrkel_pkg::CTRL_PDR_BIT];
    end
    if (rd_done)
      int_n_nxt = 1'b1;
    if (tick_hit)
      tick_nxt = '0;
    else if (active_r)
      tick_nxt = tick_r + 32'h1;
    if (clear)
    begin
      wr_ptr_nxt = '0;
      rd_ptr_nxt = '0;
      cur_ptr_nxt = '0;
      cnt_nxt = '0;
      active_nxt = 1'b0;
      tick_nxt = '0;
      int_n_nxt = 1'b1;
    end
    else
    begin
      if (pop)
      begin
        rd_ptr_nxt = rd_ptr_r + PTR_ONE;
        cnt_nxt = cnt_r - 4'h1;
      end
      if (push)
      begin
        cur_ptr_nxt = wr_ptr_r;
        wr_ptr_nxt = wr_ptr_r + PTR_ONE;
        active_nxt = 1'b1;
        tick_nxt = '0;
        int_n_nxt = 1'b0;
        if (cnt_r == CNT_FULL)
          rd_ptr_nxt = rd_ptr_r + PTR_ONE;
        else
          cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  // drive is floated by the control bit, power-down and the shutdown pin
  assign force_nxt = fde_nxt && !pdr_nxt && shutdown_pin_n_s2_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        key_r[i] <= wrkel_pkg::KEY_RESET;
        dur_r[i] <= wrkel_pkg::DUR_RESET;
      end
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cur_ptr_r <= '0;
      cnt_r <= '0;
      active_r <= 1'b0;
      tick_r <= '0;
      int_n_o <= 1'b1;
      fde_r <= wrkel_pkg::FDE_RESET;
      pdr_r <= wrkel_pkg::PDR_RESET;
      force_drive_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end
    else
    begin
      key_r <= key_nxt;
      dur_r <= dur_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cur_ptr_r <= cur_ptr_nxt;
      cnt_r <= cnt_nxt;
      active_r <= active_nxt;
      tick_r <= tick_nxt;
      int_n_o <= int_n_nxt;
      fde_r <= fde_nxt;
      pdr_r <= pdr_nxt;
      force_drive_oe_o <= force_nxt;
      // one extra flop; sda is only ever pulled low
      sda_oe_o <= i2c_oe;
      sda_o <= 1'b0;
    end
  end
endmodule : wrkel_logger

// File: hw/wrkel_pkg.sv
// shared constants of the wired-remote key event logger
package wrkel_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TICK_MS = 32;
  localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_MHZ * 1000;
  localparam int FIFO_DEPTH = 8;
  localparam int EVBUF_DEPTH = 2;
  localparam int CTRL_FDE_BIT = 7;
  localparam int CTRL_PDR_BIT = 6;
  localparam int CTRL_EMPTY_BIT = 5;
  localparam logic FDE_RESET = 1'b1;
  localparam logic PDR_RESET = 1'b0;
  localparam logic [4:0] CTRL_UNUSED_READ = 5'h00;
  localparam logic [7:0] KEY_RESET = 8'hff;
  localparam logic [7:0] DUR_RESET = 8'h00;
  localparam int DUR_OVF_BIT = 7;
  localparam logic [6:0] DUR_COUNT_MAX = 7'h7f;
  localparam logic [4:0] ADDR_UPPER = 5'h08;
  // arbitrary identification value
  localparam logic [7:0] ID_VALUE = 8'h3c;
  localparam logic [1:0] BYTE_ID = 2'h0;
  localparam logic [1:0] BYTE_CTRL = 2'h1;
  localparam logic [1:0] BYTE_KEY = 2'h2;
  localparam logic [1:0] BYTE_DUR = 2'h3;
endpackage : wrkel_pkg

// File: tb/tb_top.sv
// self-checking bench for the key event logger
`timescale 1ns/100ps
module tb_top;
  localparam int TICK = 50;
  localparam int DEB = 20;
  // arbitrary identification value
  localparam logic [7:0] ID = 8'h5a;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] key_code_i = 8'hff;
  logic shutdown_pin_n_i = 1'b1;
  logic addr_select_1_i = 1'b0;
  logic addr_select_0_i = 1'b0;
  logic scl, mlow, sda_o, sda_oe_o, int_n_o, force_drive_oe_o, na, nd;
  logic fde = 1'b1;
  logic pdr = 1'b0;
  logic exp_int = 1'b1;
  logic [6:0] dev_a = 7'h20;
  logic [7:0] qk[$];
  logic [7:0] qd[$];
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int t_last = 0;
  int prev = 255;
  int seed = 32'h608f;
  // pulled-up data line
  wire sda = !(sda_oe_o || mlow);
  wrkel_logger #(
    .TICK_CYCLES(TICK),
    .DEBOUNCE_CYCLES(DEB),
    .ID_VALUE(ID)
  ) dut_u (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .key_code_i(key_code_i),
    .shutdown_pin_n_i(shutdown_pin_n_i), .addr_select_1_i(addr_select_1_i),
    .addr_select_0_i(addr_select_0_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
    .force_drive_oe_o(force_drive_oe_o)
  );
  wrkel_host_model host_u (.scl_o(scl), .sda_low_o(mlow), .sda_i(sda));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cycles
  function automatic logic [7:0] enc(input int k);
    return {k > 127, 7'(k)};
  endfunction : enc
  task ev(input logic [7:0] c, input int kmin);
    int k;
    if (qk.size() > 0)
    begin
      // land mid-tick so the frozen count is unambiguous
      k = (cyc - t_last) / TICK + 1;
      if (k < kmin)
        k = kmin;
      while (cyc < t_last + k * TICK + TICK / 2)
        @(posedge clk_i);
      qd[qk.size() - 1] = enc(k);
    end
    @(posedge clk_i);
    key_code_i <= c;
    qk.push_back(c);
    qd.push_back(8'h00);
    if (qk.size() > 8)
    begin
      void'(qk.pop_front());
      void'(qd.pop_front());
    end
    t_last = cyc;
    prev = c;
    exp_int = 1'b0;
  endtask : ev
  task press_rand(input int kmin);
    int k;
    k = {$random(seed)} % 254;
    if (k >= prev)
      k++;
    ev(8'(k), kmin);
  endtask : press_rand
  task rdc(input logic mack);
    logic [7:0] b0, b1, b2, b3, ek, ed;
    logic n;
    ek = qk.size() ? qk[0] : 8'hff;
    ed = qk.size() ? qd[0] : 8'h00;
    host_u.rd(dev_a, mack, b0, b1, b2, b3, n);
    chk({7'h0, n}, 8'h00);
    chk(b0, ID);
    chk(b1, {fde, pdr, qk.size() == 0, 5'h00});
    chk(b2, ek);
    if (qk.size() != 1)
      chk(b3, ed);
    if (mack)
    begin
      exp_int = 1'b1;
      if (qk.size() > 1)
      begin
        void'(qk.pop_front());
        void'(qd.pop_front());
      end
    end
    cycles(10);
    chk({7'h0, int_n_o}, {7'h0, exp_int});
  endtask : rdc
  task wrc(input logic [7:0] v);
    host_u.wr(dev_a, v, na, nd);
    chk({6'h0, na, nd}, 8'h00);
    fde = v[7];
    pdr = v[6];
    if (v[6])
    begin
      qk.delete();
      qd.delete();
      exp_int = 1'b1;
    end
    cycles(10);
    chk({7'h0, force_drive_oe_o}, {7'h0, v[7] & !v[6]});
  endtask : wrc
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cycles(6);
    // bounce shorter than the debounce window
    key_code_i <= 8'h11;
    cycles(DEB / 2);
    key_code_i <= 8'hff;
    cycles(2 * DEB);
    chk({7'h0, int_n_o}, 8'h01);
    for (int a = 0; a < 4; a++)
    begin
      addr_select_1_i <= a[1];
      addr_select_0_i <= a[0];
      dev_a = {5'h08, a[1:0]};
      cycles(4);
      rdc(1'b1);
    end
    host_u.wr(7'h2b, 8'h00, na, nd);
    chk({7'h0, na}, 8'h01);
    wrc(8'h9f);
    rdc(1'b1);
    wrc(8'h40);
    rdc(1'b1);
    wrc(8'h80);
    press_rand(1);
    cycles(DEB + 10);
    chk({7'h0, int_n_o}, 8'h00);
    rdc(1'b1);
    rdc(1'b1);
    ev(8'hff, 1);
    cycles(DEB + 10);
    chk({7'h0, int_n_o}, 8'h00);
    rdc(1'b0);
    rdc(1'b1);
    press_rand(1);
    ev(8'hff, 130);
    rdc(1'b1);
    rdc(1'b1);
    repeat (9)
      press_rand(1);
    ev(8'hff, 1);
    repeat (9)
      rdc(1'b1);
    @(posedge clk_i);
    shutdown_pin_n_i <= 1'b0;
    qk.delete();
    qd.delete();
    exp_int = 1'b1;
    cycles(10);
    chk({6'h0, int_n_o, force_drive_oe_o}, 8'h02);
    shutdown_pin_n_i <= 1'b1;
    cycles(10);
    rdc(1'b1);
    // second reset in mid-run
    rst_b_i <= 1'b0;
    cycles(4);
    rst_b_i <= 1'b1;
    cycles(6);
    rdc(1'b1);
    print_verdict();
  end
endmodule : tb_top

// File: tb/wrkel_host_model.sv
// two-wire bus master model for the logger's serial port
`timescale 1ns/100ps
module wrkel_host_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  // 48 ns bus period, free of the logger's clock
  localparam int HALF = 24;
  localparam int QTR = 12;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task bit_c(input logic b, output logic s);
    sda_low_o = !b;
    #QTR;
    scl_o = 1'b1;
    #HALF;
    s = sda_i;
    scl_o = 1'b0;
    #QTR;
  endtask : bit_c
  task start_c;
    sda_low_o = 1'b0;
    #QTR;
    scl_o = 1'b1;
    #HALF;
    sda_low_o = 1'b1;
    #HALF;
    scl_o = 1'b0;
    #QTR;
  endtask : start_c
  task stop_c;
    sda_low_o = 1'b1;
    #QTR;
    scl_o = 1'b1;
    #HALF;
    sda_low_o = 1'b0;
    #HALF;
  endtask : stop_c
  task xbyte(input logic [7:0] d, input logic a9, output logic [7:0] r,
      output logic s9);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], r[i]);
    bit_c(a9, s9);
  endtask : xbyte
  task wr(input logic [6:0] a, input logic [7:0] v, output logic na,
      output logic nd);
    logic [7:0] junk;
    start_c();
    xbyte({a, 1'b0}, 1'b1, junk, na);
    xbyte(v, 1'b1, junk, nd);
    stop_c();
  endtask : wr
  task rd(input logic [6:0] a, input logic ack, output logic [7:0] b0,
      output logic [7:0] b1, output logic [7:0] b2, output logic [7:0] b3,
      output logic na);
    logic s;
    start_c();
    xbyte({a, 1'b1}, 1'b1, b0, na);
    xbyte(8'hff, 1'b0, b0, s);
    xbyte(8'hff, 1'b0, b1, s);
    xbyte(8'hff, 1'b0, b2, s);
    xbyte(8'hff, !ack, b3, s);
    stop_c();
  endtask : rd
endmodule : wrkel_host_model

// File: tb/wrkel_logger_props.sv
// port assertions for the key event logger
`timescale 1ns/100ps
module wrkel_logger_props #(
  parameter int unsigned TICK_CYCLES = 1,
  parameter int unsigned DEBOUNCE_CYCLES = 1,
  parameter logic [7:0] ID_VALUE = 8'h00
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] key_code_i,
  input wire logic shutdown_pin_n_i,
  input wire logic addr_select_1_i,
  input wire logic addr_select_0_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic int_n_o,
  input wire logic force_drive_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [7:0] key_q_r;
  int unsigned stab_r;
  int unsigned stab_nxt;
  // cycles the sense code has held still
  always_comb
  begin
    stab_nxt = stab_r + 1;
    if (key_code_i != key_q_r)
      stab_nxt = 0;
  end
  // cleared in reset so the count is known before the first key change
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      key_q_r <= key_code_i;
      stab_r <= 0;
    end
    else
    begin
      key_q_r <= key_code_i;
      stab_r <= stab_nxt;
    end
  end
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data output not low");
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !sda_oe_o && int_n_o)
    else $error("outputs busy right after reset");
  a_debounce_held: assert property ($fell(int_n_o) |-> stab_r >= DEBOUNCE_CYCLES)
    else $error("interrupt before code settled");
  a_shutdown_pin_n_floats: assert property (!shutdown_pin_n_i [*4] |-> !force_drive_oe_o)
    else $error("drive enabled in shutdown");
  a_shutdown_pin_n_no_int: assert property (!shutdown_pin_n_i [*4] |-> int_n_o)
    else $error("interrupt held in shutdown");
  a_drive_after_rst: assert property ($rose(rst_b_i) && shutdown_pin_n_i |-> ##[0:4] force_drive_oe_o)
    else $error("drive not enabled after reset");
  a_ack_spans_bit: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("data pull-down too short");
  a_oe_still_high: assert property (scl_i [*4] |-> $stable(sda_oe_o))
    else $error("data changed while clock high");
endmodule : wrkel_logger_props
bind wrkel_logger wrkel_logger_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
  .ID_VALUE(ID_VALUE)
) props_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .key_code_i(key_code_i),
  .shutdown_pin_n_i(shutdown_pin_n_i), .addr_select_1_i(addr_select_1_i),
  .addr_select_0_i(addr_select_0_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_n_o(int_n_o),
  .force_drive_oe_o(force_drive_oe_o)
);
